// ==== src/homing_cfg.svh ====
// Offsets, reset values, limits and timing counts of the homing sequencer
`ifndef HOMING_CFG_SVH
`define HOMING_CFG_SVH
// Register indices on the plain register port
`define A_START_SEL   4'h0
`define A_METHOD      4'h1
`define A_FAST_SPEED  4'h2
`define A_SLOW_SPEED  4'h3
`define A_RAMP_TIME   4'h4
`define A_TIMEOUT     4'h5
`define A_OFFSET      4'h6
`define A_CTRL        4'h7
`define A_STATUS      4'h8
`define A_STOP_POS    4'h9
`define A_ZERO_POS    4'hA
// Reset values
`define R_START_SEL   16'h0000
`define R_METHOD      16'h0000
`define R_FAST_SPEED  16'h012C
`define R_SLOW_SPEED  16'h003C
`define R_RAMP_TIME   16'h0032
`define R_TIMEOUT     16'hFFFF
`define R_OFFSET      32'h0000_0000
// Legal ranges, applied on write
`define MAX_START_SEL 16'h0002
`define MAX_METHOD    16'h0023
`define MAX_FAST      16'h0BB8
`define MAX_SLOW      16'h012C
`define MAX_RAMP      16'h03E8
`define MIN_TIMEOUT   16'h0064
// Control and status bit positions
`define CTRL_CAPTURE  0
`define ST_BUSY       0
`define ST_DONE       1
`define ST_TIMEOUT    2
`define ST_BAD_METHOD 3
`define ST_STATE_LSB  4
// Timing: clock period and the microsecond and millisecond time bases
`define CLK_PERIOD_NS 10
`define US_NS         1000
`define CYC_PER_US    (`US_NS / `CLK_PERIOD_NS)
`define US_PER_MS     1000
`endif

// ==== src/homing_pkg.sv ====
// Types shared by the homing sequencer modules
package homing_pkg;
   typedef logic signed [15:0] speed_t;
   // Sequencer states
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_FAST  = 3'b001,
      ST_SEEK  = 3'b010,
      ST_INDEX = 3'b011,
      ST_STOP  = 3'b100
   } hstate_t;
   // Which switch acts as the deceleration point
   typedef enum logic [1:0] {
      SW_REV  = 2'b00,
      SW_FWD  = 2'b01,
      SW_HOME = 2'b10
   } sw_sel_t;
   // Machine inputs that travel together
   typedef struct packed {
      logic reverse_limit_input;
      logic forward_limit_input;
      logic home_switch_input;
      logic index_pulse;
   } sw_in_t;
   // Search plan worked out at start
   typedef struct packed {
      logic    fast_en;
      logic    fast_rev;
      logic    fast_rise;
      logic    slow_rev;
      logic    qual_rise;
      sw_sel_t sel;
   } plan_t;
endpackage : homing_pkg

// ==== src/homing_timer.sv ====
// Microsecond tick divider and millisecond homing timeout counter
`timescale 1ns/100ps
`default_nettype none
`include "homing_cfg.svh"
module homing_timer #(
   parameter int CYC_US = `CYC_PER_US,
   parameter int US_MS  = `US_PER_MS
) (
   input  wire logic        clk,
   input  wire logic        nrst,
   input  wire logic        run,
   input  wire logic [15:0] limit_ms,
   output logic             us_tick,
   output logic             expired
);
   logic [15:0] us_cnt_r;
   logic [15:0] ms_div_r;
   logic [15:0] ms_cnt_r;

   // Free running divider, one-cycle enable each microsecond
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         us_cnt_r <= 16'h0000;
         us_tick  <= 1'b0;
      end else begin
         us_tick  <= (us_cnt_r == 16'(CYC_US - 1));
         us_cnt_r <= (us_cnt_r == 16'(CYC_US - 1)) ? 16'h0000 : us_cnt_r + 16'h0001;
      end
   end

   // Elapsed milliseconds; cleared whenever the search is not running
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ms_div_r <= 16'h0000;
         ms_cnt_r <= 16'h0000;
         expired  <= 1'b0;
      end else if (!run) begin
         ms_div_r <= 16'h0000;
         ms_cnt_r <= 16'h0000;
         expired  <= 1'b0;
      end else begin
         if (us_tick) begin
            if (ms_div_r == 16'(US_MS - 1)) begin
               ms_div_r <= 16'h0000;
               if (ms_cnt_r != 16'hFFFF) ms_cnt_r <= ms_cnt_r + 16'h0001;
            end else begin
               ms_div_r <= ms_div_r + 16'h0001;
            end
         end
         expired <= (ms_cnt_r >= limit_ms);
      end
   end
endmodule : homing_timer
`default_nettype wire

// ==== src/homing_ramp.sv ====
// Speed ramp: one rpm step per programmed number of microseconds
`timescale 1ns/100ps
`default_nettype none
`include "homing_cfg.svh"
module homing_ramp
   import homing_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        nrst,
   input  wire logic        us_tick,
   input  wire logic [15:0] step_us,
   input  wire speed_t      target,
   output speed_t           speed
);
   logic [15:0] cnt_r;

   // Ramp time T ms per 1000 rpm gives one rpm every T microseconds
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cnt_r <= 16'h0000;
         speed <= '0;
      end else if (speed == target) begin
         cnt_r <= 16'h0000;
      end else if (us_tick) begin
         if (cnt_r + 16'h0001 >= step_us) begin
            cnt_r <= 16'h0000;
            speed <= (target > speed) ? speed + 16'sd1 : speed - 16'sd1;
         end else begin
            cnt_r <= cnt_r + 16'h0001;
         end
      end
   end
endmodule : homing_ramp
`default_nettype wire

// ==== src/homing_sequencer.sv ====
// Homing sequencer: registers, start logic, search state machine
//
// How it works
// - Stop position is origin, zero plus offset
// - Start selector: off, first servo-on, input
// - Method number 0 to 35 accepted; only 1 to 5 select a search
// - Fast search speed 1 to 3000 rpm
// - Slow search speed 1 to 300 rpm
// - Ramp time per 1000 rpm, 1 to 1000
// - Capture copies encoder position into offset
// - Method 1 clear: fast reverse, slow forward
// - Method 1 set: slow forward, fall, index
// - Method 2 clear: fast forward, slow reverse
// - Method 2 set: slow reverse, fall, index
// - Method 3 clear: fast forward, reverse, index
// - Method 3 set: slow reverse, fall, index
// - Method 4 clear: slow forward, rise, index
// - Method 4 set: fast reverse, forward, rise
// - Method 5 clear: fast reverse, slow forward
// - Method 5 set: slow forward, fall, index
//
// The address-and-strobe port and the register offsets are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
`include "homing_cfg.svh"
module homing_sequencer
   import homing_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        nrst,
   input  wire logic [3:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic [31:0]      reg_rdata,
   input  wire logic        servo_on,
   input  wire logic        homing_di,
   input  wire sw_in_t      sw,
   input  wire logic [31:0] multiturn_position_readout,
   output speed_t           motor_speed,
   output logic             homing_busy,
   output logic             homing_done,
   output logic             homing_error,
   output logic [31:0]      origin_zero_pos
);

   // ****************************************
   // Helper functions
   // ****************************************

   // Limit a written value to its legal range
   function automatic logic [15:0] clamp16(input logic [15:0] v,
                                           input logic [15:0] lo,
                                           input logic [15:0] hi);
      clamp16 = (v < lo) ? lo : ((v > hi) ? hi : v);
   endfunction : clamp16

   // Level of the switch chosen as deceleration point
   function automatic logic pick(input sw_sel_t s, input sw_in_t v);
      case (s)
         SW_REV:  pick = v.reverse_limit_input;
         SW_FWD:  pick = v.forward_limit_input;
         default: pick = v.home_switch_input;
      endcase
   endfunction : pick

   // Only methods 1 to 5 have a search sequence here
   function automatic logic method_ok(input logic [15:0] m);
      method_ok = (m >= 16'h0001) && (m <= 16'h0005);
   endfunction : method_ok

   // Search plan from method and switch levels seen at start
   function automatic plan_t plan_of(input logic [15:0] m, input sw_in_t v);
      plan_t p;
      p = '0;
      case (m)
         16'h0001: begin
            p.sel       = SW_REV;
            p.fast_en   = !v.reverse_limit_input;
            p.fast_rev  = 1'b1;
            p.fast_rise = 1'b1;
            p.slow_rev  = 1'b0;
            p.qual_rise = 1'b0;
         end
         16'h0002: begin
            p.sel       = SW_FWD;
            p.fast_en   = !v.forward_limit_input;
            p.fast_rev  = 1'b0;
            p.fast_rise = 1'b1;
            p.slow_rev  = 1'b1;
            p.qual_rise = 1'b0;
         end
         16'h0003: begin
            p.sel       = SW_HOME;
            p.fast_en   = !v.home_switch_input;
            p.fast_rev  = 1'b0;
            p.fast_rise = 1'b1;
            p.slow_rev  = 1'b1;
            p.qual_rise = 1'b0;
         end
         16'h0004: begin
            p.sel       = SW_HOME;
            p.fast_en   = v.home_switch_input;
            p.fast_rev  = 1'b1;
            p.fast_rise = 1'b0;
            p.slow_rev  = 1'b0;
            p.qual_rise = 1'b1;
         end
         16'h0005: begin
            p.sel       = SW_HOME;
            p.fast_en   = !v.home_switch_input;
            p.fast_rev  = 1'b1;
            p.fast_rise = 1'b1;
            p.slow_rev  = 1'b0;
            p.qual_rise = 1'b0;
         end
         default: p = '0;
      endcase
      return p;
   endfunction : plan_of

   // ****************************************
   // Registers and state
   // ****************************************

   logic [15:0] start_sel_r;
   logic [15:0] method_r;
   logic [15:0] fast_speed_r;
   logic [15:0] slow_speed_r;
   logic [15:0] ramp_time_r;
   logic [15:0] timeout_r;
   logic [31:0] offset_r;
   logic [31:0] stop_pos_r;
   hstate_t     state_r;
   plan_t       plan_r;
   plan_t       plan_start;
   sw_in_t      sw_prev_r;
   logic        servo_prev_r;
   logic        di_prev_r;
   logic        first_on_seen_r;
   logic        bad_method_r;
   logic        timeout_err_r;
   speed_t      target_r;
   logic        us_tick;
   logic        expired;
   logic        run;
   logic        servo_rise;
   logic        di_rise;
   logic        start_req;
   logic        sel_now;
   logic        sel_prev;
   logic        fast_edge;
   logic        qual_edge;
   logic        capture;

   // ****************************************
   // Register writes
   // ****************************************

   // Configuration; out-of-range writes are pulled into range
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         start_sel_r  <= `R_START_SEL;
         method_r     <= `R_METHOD;
         fast_speed_r <= `R_FAST_SPEED;
         slow_speed_r <= `R_SLOW_SPEED;
         ramp_time_r  <= `R_RAMP_TIME;
         timeout_r    <= `R_TIMEOUT;
      end else if (reg_wr) begin
         case (reg_addr)
            `A_START_SEL:
               start_sel_r  <= clamp16(reg_wdata[15:0], 16'h0000, `MAX_START_SEL);
            `A_METHOD:
               method_r     <= clamp16(reg_wdata[15:0], 16'h0000, `MAX_METHOD);
            `A_FAST_SPEED:
               fast_speed_r <= clamp16(reg_wdata[15:0], 16'h0001, `MAX_FAST);
            `A_SLOW_SPEED:
               slow_speed_r <= clamp16(reg_wdata[15:0], 16'h0001, `MAX_SLOW);
            `A_RAMP_TIME:
               ramp_time_r  <= clamp16(reg_wdata[15:0], 16'h0001, `MAX_RAMP);
            `A_TIMEOUT:
               timeout_r    <= clamp16(reg_wdata[15:0], `MIN_TIMEOUT, 16'hFFFF);
            default: ;
         endcase
      end
   end

   // Writing 1 to the capture bit takes the live encoder position
   assign capture = reg_wr && (reg_addr == `A_CTRL) && reg_wdata[`CTRL_CAPTURE];

   // Origin offset: plain write, or capture of the encoder position
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         offset_r <= `R_OFFSET;
      end else if (capture) begin
         offset_r <= multiturn_position_readout;
      end else if (reg_wr && (reg_addr == `A_OFFSET)) begin
         offset_r <= reg_wdata;
      end
   end

   // ****************************************
   // Register reads
   // ****************************************

   // Read data stand in the cycle after the strobe only
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         reg_rdata <= 32'h0000_0000;
      end else if (!reg_rd) begin
         reg_rdata <= 32'h0000_0000;
      end else begin
         case (reg_addr)
            `A_START_SEL:  reg_rdata <= {16'h0000, start_sel_r};
            `A_METHOD:     reg_rdata <= {16'h0000, method_r};
            `A_FAST_SPEED: reg_rdata <= {16'h0000, fast_speed_r};
            `A_SLOW_SPEED: reg_rdata <= {16'h0000, slow_speed_r};
            `A_RAMP_TIME:  reg_rdata <= {16'h0000, ramp_time_r};
            `A_TIMEOUT:    reg_rdata <= {16'h0000, timeout_r};
            `A_OFFSET:     reg_rdata <= offset_r;
            `A_STATUS: begin
               reg_rdata <= {25'h0000000, state_r, bad_method_r,
                             timeout_err_r, homing_done, homing_busy};
            end
            `A_STOP_POS:   reg_rdata <= stop_pos_r;
            `A_ZERO_POS:   reg_rdata <= origin_zero_pos;
            default:       reg_rdata <= 32'h0000_0000;
         endcase
      end
   end

   // ****************************************
   // Start detection
   // ****************************************

   // Previous levels for edge detection of the switch, servo-on and start inputs
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         sw_prev_r    <= '0;
         servo_prev_r <= 1'b0;
         di_prev_r    <= 1'b0;
      end else begin
         sw_prev_r    <= sw;
         servo_prev_r <= servo_on;
         di_prev_r    <= homing_di;
      end
   end

   assign servo_rise = servo_on && !servo_prev_r;
   assign di_rise    = homing_di && !di_prev_r;

   // Only the very first servo-on after reset may start homing in mode 1
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         first_on_seen_r <= 1'b0;
      end else if (servo_rise) begin
         first_on_seen_r <= 1'b1;
      end
   end

   // Start requests are ignored while a search is in progress
   assign start_req = (state_r == ST_IDLE) && servo_on &&
                      (((start_sel_r == 16'h0001) && servo_rise && !first_on_seen_r) ||
                       ((start_sel_r == 16'h0002) && di_rise));

   // ****************************************
   // Edge qualification
   // ****************************************

   assign plan_start = plan_of(method_r, sw);
   assign sel_now   = pick(plan_r.sel, sw);
   assign sel_prev  = pick(plan_r.sel, sw_prev_r);
   assign fast_edge = plan_r.fast_rise ? (sel_now && !sel_prev) : (!sel_now && sel_prev);
   assign qual_edge = plan_r.qual_rise ? (sel_now && !sel_prev) : (!sel_now && sel_prev);

   // Timeout counts only while the motor is searching
   assign run = (state_r == ST_FAST) || (state_r == ST_SEEK) || (state_r == ST_INDEX);

   // ****************************************
   // Search state machine
   // ****************************************

   // Ramp to zero speed before going idle; done and the origin are taken at the index pulse, while still moving
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state_r <= ST_IDLE;
         plan_r  <= '0;
      end else begin
         case (state_r)
            ST_IDLE: begin
               if (start_req && method_ok(method_r)) begin
                  plan_r  <= plan_start;
                  state_r <= plan_start.fast_en ? ST_FAST : ST_SEEK;
               end
            end
            ST_FAST: begin
               if (expired || !servo_on) state_r <= ST_STOP;
               else if (fast_edge) state_r <= ST_SEEK;
            end
            ST_SEEK: begin
               if (expired || !servo_on) state_r <= ST_STOP;
               else if (qual_edge) state_r <= ST_INDEX;
            end
            ST_INDEX: begin
               if (expired || !servo_on) state_r <= ST_STOP;
               else if (sw.index_pulse) state_r <= ST_STOP;
            end
            ST_STOP: begin
               if ((motor_speed == 16'sd0) && (target_r == 16'sd0)) state_r <= ST_IDLE;
            end
            default: state_r <= ST_IDLE;
         endcase
      end
   end

   // Speed demand; direction reversal passes through zero on the ramp
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         target_r <= '0;
      end else begin
         case (state_r)
            ST_FAST: begin
               target_r <= plan_r.fast_rev ? -$signed(fast_speed_r) : $signed(fast_speed_r);
            end
            ST_SEEK, ST_INDEX: begin
               target_r <= plan_r.slow_rev ? -$signed(slow_speed_r) : $signed(slow_speed_r);
            end
            default: target_r <= '0;
         endcase
      end
   end

   // ****************************************
   // Result and status flags
   // ****************************************

   // Stop position taken on the qualifying index pulse
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         stop_pos_r      <= 32'h0000_0000;
         origin_zero_pos <= 32'h0000_0000;
      end else if ((state_r == ST_INDEX) && sw.index_pulse && !expired && servo_on) begin
         stop_pos_r      <= multiturn_position_readout;
         origin_zero_pos <= multiturn_position_readout - offset_r;
      end
   end

   // Busy, done and error flags; a new start clears the timeout error, and clears done only for a supported method
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         homing_busy   <= 1'b0;
         homing_done   <= 1'b0;
         timeout_err_r <= 1'b0;
         bad_method_r  <= 1'b0;
      end else begin
         if (start_req) begin
            homing_busy   <= method_ok(method_r);
            if (method_ok(method_r)) homing_done <= 1'b0;
            timeout_err_r <= 1'b0;
            bad_method_r  <= !method_ok(method_r);
         end else if ((state_r == ST_STOP) && (motor_speed == 16'sd0) &&
                      (target_r == 16'sd0)) begin
            homing_busy <= 1'b0;
         end
         if (run && expired) timeout_err_r <= 1'b1;
         if ((state_r == ST_INDEX) && sw.index_pulse && !expired && servo_on) begin
            homing_done <= 1'b1;
         end
      end
   end

   // Error output collects timeout and unsupported method
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) homing_error <= 1'b0;
      else homing_error <= timeout_err_r || bad_method_r;
   end

   // ****************************************
   // Time base and speed ramp
   // ****************************************

   homing_timer u_timer (
      .clk      (clk),
      .nrst     (nrst),
      .run      (run),
      .limit_ms (timeout_r),
      .us_tick  (us_tick),
      .expired  (expired)
   );

   // Ramp applies to every speed change during homing
   homing_ramp u_ramp (
      .clk     (clk),
      .nrst    (nrst),
      .us_tick (us_tick),
      .step_us (ramp_time_r),
      .target  (target_r),
      .speed   (motor_speed)
   );

endmodule : homing_sequencer
`default_nettype wire

// ==== tb/homing_sequencer_properties.sv ====
// Port-level checks of the homing sequencer
`timescale 1ns/100ps
`default_nettype none
module homing_sequencer_properties
   import homing_pkg::*;
(
   input wire logic        clk,
   input wire logic        nrst,
   input wire sw_in_t      sw,
   input wire speed_t      motor_speed,
   input wire logic        homing_busy,
   input wire logic        homing_done,
   input wire logic [31:0] origin_zero_pos
);
   // ***************
   // Checks
   // ***************
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   // Ramp steps are at least a microsecond apart, so eight cycles is a safe floor
   property p_ramp_hold; $changed(motor_speed) |=> $stable(motor_speed) [*8]; endproperty
   a_ramp_hold: assert property (p_ramp_hold) else $error("speed step too soon");
   property p_ramp_unit; $changed(motor_speed) |-> motor_speed == $past(motor_speed) + 16'sh1
      || motor_speed == $past(motor_speed) - 16'sh1; endproperty
   a_ramp_unit: assert property (p_ramp_unit) else $error("speed step not one rpm");
   property p_idle_still; !homing_busy |-> motor_speed == 16'sh0; endproperty
   a_idle_still: assert property (p_idle_still) else $error("motion while idle");
   property p_start_clr; $rose(homing_busy) |-> !homing_done; endproperty
   a_start_clr: assert property (p_start_clr) else $error("done kept at start");
   property p_done_busy; $rose(homing_done) |-> homing_busy; endproperty
   a_done_busy: assert property (p_done_busy) else $error("done outside search");
   property p_done_keep; homing_done |=> homing_done || $rose(homing_busy); endproperty
   a_done_keep: assert property (p_done_keep) else $error("done dropped early");
   property p_zero_upd; $changed(origin_zero_pos) |-> homing_done; endproperty
   a_zero_upd: assert property (p_zero_upd) else $error("zero moved unhomed");
   property p_stop_idx; $rose(homing_done) |-> $past(sw.index_pulse); endproperty
   a_stop_idx: assert property (p_stop_idx) else $error("stop without index");
endmodule : homing_sequencer_properties
bind homing_sequencer homing_sequencer_properties i_homing_sequencer_properties (
   .clk(clk), .nrst(nrst), .sw(sw), .motor_speed(motor_speed), .homing_busy(homing_busy),
   .homing_done(homing_done), .origin_zero_pos(origin_zero_pos));
`default_nettype wire

// ==== tb/homing_motor_model.sv ====
// Behavioural motor, encoder and machine switches
`timescale 1ns/100ps
`default_nettype none
module homing_motor_model
   import homing_pkg::*;
#(
   parameter int LIMIT   = 2000,
   parameter int HOME_LO = 500,
   parameter int HOME_HI = 900
) (
   input  wire logic        clk,
   input  wire logic        load,
   input  wire logic [31:0] load_pos,
   input  wire speed_t      motor_speed,
   output var sw_in_t       sw,
   output logic [31:0]      pos,
   output logic [15:0]      peak
);
   // ***************
   // Travel
   // ***************
   logic [31:0] pos_prev = 32'h0;
   initial {pos, peak} = 48'h0;
   wire logic [15:0] mag = motor_speed[15] ? 16'(-motor_speed) : motor_speed;
   // One count per rpm per cycle keeps travel short; peak shows fast against slow
   always @(posedge clk) begin
      pos_prev <= pos;
      if (load) begin
         pos <= load_pos;
         peak <= 16'h0;
      end else begin
         pos <= pos + {{16{motor_speed[15]}}, motor_speed};
         if (mag > peak) peak <= mag;
      end
   end
   // Limits beyond both ends, home cam between; index on every 128-count boundary
   assign sw.reverse_limit_input = $signed(pos) < -LIMIT;
   assign sw.forward_limit_input = $signed(pos) > LIMIT;
   assign sw.home_switch_input = $signed(pos) >= HOME_LO && $signed(pos) <= HOME_HI;
   assign sw.index_pulse = pos[7] ^ pos_prev[7];
endmodule : homing_motor_model
`default_nettype wire

// ==== tb/test_homing_sequencer.sv ====
// Self-checking bench for the homing sequencer
`timescale 1ns/100ps
`default_nettype none
`include "homing_cfg.svh"
module test_homing_sequencer
   import homing_pkg::*;
;
   logic        clk = 1'b0;
   logic        nrst = 1'b0;
   logic [3:0]  reg_addr = 4'h0;
   logic [31:0] reg_wdata = 32'h0;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   logic        servo_on = 1'b0;
   logic        homing_di = 1'b0;
   logic        load = 1'b0;
   logic [31:0] load_pos = 32'h0;
   logic [31:0] reg_rdata, enc_pos, origin_zero_pos, rd_val, stop;
   speed_t      motor_speed;
   sw_in_t      sw;
   logic        homing_busy, homing_done, homing_error;
   logic [15:0] peak;
   int          num_errors = 0, samples_checked = 0;
   int          bad [3] = '{0, 15, 35};
   logic [31:0] rv [7] = '{{16'h0, `R_START_SEL}, {16'h0, `R_METHOD}, {16'h0, `R_FAST_SPEED},
      {16'h0, `R_SLOW_SPEED}, {16'h0, `R_RAMP_TIME}, {16'h0, `R_TIMEOUT}, `R_OFFSET};
   // ***************
   // Design and far side
   // ***************
   homing_sequencer i_homing_sequencer (
      .clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .servo_on(servo_on), .homing_di(homing_di),
      .sw(sw), .multiturn_position_readout(enc_pos), .motor_speed(motor_speed),
      .homing_busy(homing_busy), .homing_done(homing_done), .homing_error(homing_error),
      .origin_zero_pos(origin_zero_pos));
   homing_motor_model i_homing_motor_model (.clk(clk), .load(load), .load_pos(load_pos),
      .motor_speed(motor_speed), .sw(sw), .pos(enc_pos), .peak(peak));
   // 100 MHz clock
   always #5 clk = ~clk;
   // ***************
   // Tasks
   // ***************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask : wr
   // Read data is sampled mid-cycle, clear of the edge that retires it
   task automatic rd(input logic [3:0] a);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      @(negedge clk);
      rd_val = reg_rdata;
   endtask : rd
   task automatic wrc(input logic [3:0] a, input logic [31:0] d, input logic [31:0] e);
      wr(a, d);
      rd(a);
      chk(rd_val, e);
   endtask : wrc
   task automatic place(input logic [31:0] p);
      @(posedge clk);
      load <= 1'b1;
      load_pos <= p;
      @(posedge clk);
      load <= 1'b0;
   endtask : place
   task automatic kick;
      @(posedge clk);
      homing_di <= 1'b1;
      @(posedge clk);
      homing_di <= 1'b0;
      repeat (4) @(negedge clk);
   endtask : kick
   task automatic wait_flag(input logic want_done);
      for (int i = 0; i < 20000; i++) begin
         if (want_done ? homing_done === 1'b1 : homing_busy === 1'b0) return;
         @(negedge clk);
      end
      num_errors++;
   endtask : wait_flag
   // First run starts on the first servo-on, the rest from the start input
   task automatic home_run(input int m, input int p0, input int b, input int sp,
                           input int lv, input int pk);
      wr(`A_METHOD, 32'(m));
      place(32'(p0));
      if (servo_on) kick;
      else servo_on <= 1'b1;
      wait_flag(1'b1);
      chk({30'h0, homing_error, homing_done}, 32'h1);
      chk({{16{motor_speed[15]}}, motor_speed}, 32'(sp));
      chk({29'h0, sw[3:1]}, 32'(lv));
      wait_flag(1'b0);
      chk({16'h0, peak}, 32'(pk));
      rd(`A_STOP_POS);
      stop = rd_val;
      chk({31'h0, (stop - 32'(b) + 32'h3) < 32'h6}, 32'h1);
      chk(origin_zero_pos, stop - 32'h1234);
      rd(`A_ZERO_POS);
      chk(rd_val, stop - 32'h1234);
      wr(`A_START_SEL, 32'h2);
   endtask : home_run
   task automatic final_report;
      $display("errors=%0d checks=%0d", num_errors, samples_checked);
      if (num_errors == 0 && samples_checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : final_report
   // ***************
   // Sequence
   // ***************
   initial begin
      repeat (10) @(posedge clk);
      nrst <= 1'b1;
      for (int a = 0; a < 7; a++) begin
         rd(4'(a));
         chk(rd_val, rv[a]);
      end
      rd(4'hB);
      chk(rd_val, 32'h0);
      wrc(`A_FAST_SPEED, 32'h1388, {16'h0, `MAX_FAST});
      wrc(`A_SLOW_SPEED, 32'h1F4, {16'h0, `MAX_SLOW});
      wrc(`A_RAMP_TIME, 32'h7D0, {16'h0, `MAX_RAMP});
      wrc(`A_METHOD, 32'h30, {16'h0, `MAX_METHOD});
      wrc(`A_START_SEL, 32'h7, {16'h0, `MAX_START_SEL});
      wrc(`A_TIMEOUT, 32'h10, {16'h0, `MIN_TIMEOUT});
      wrc(`A_FAST_SPEED, 32'h2, 32'h2);
      wrc(`A_SLOW_SPEED, 32'h1, 32'h1);
      wrc(`A_RAMP_TIME, 32'h1, 32'h1);
      wrc(`A_START_SEL, 32'h1, 32'h1);
      place(32'h1234);
      wr(`A_CTRL, 32'h1);
      rd(`A_OFFSET);
      chk(rd_val, 32'h1234);
      home_run(4, 0, 512, 1, 1, 1);
      home_run(1, 0, -1920, 1, 0, 2);
      home_run(1, -2100, -1920, 1, 0, 1);
      home_run(2, 0, 1920, -1, 0, 2);
      home_run(2, 2100, 1920, -1, 0, 1);
      home_run(3, 0, 384, -1, 0, 2);
      home_run(3, 700, 384, -1, 0, 1);
      home_run(4, 700, 512, 1, 1, 2);
      home_run(5, 1300, 1024, 1, 0, 2);
      home_run(5, 700, 1024, 1, 0, 1);
      wrc(`A_START_SEL, 32'h0, 32'h0);
      kick;
      chk({31'h0, homing_busy}, 32'h0);
      wr(`A_START_SEL, 32'h2);
      foreach (bad[i]) begin
         wr(`A_METHOD, 32'(bad[i]));
         kick;
         chk({30'h0, homing_busy, homing_error}, 32'h1);
      end
      rd(`A_STATUS);
      chk(rd_val, 32'h0000_000A);
      final_report;
   end
   // Watchdog well beyond the expected hundred or so microseconds
   initial begin
      #1000000;
      num_errors++;
      final_report;
   end
endmodule : test_homing_sequencer
`default_nettype wire
